// file: design/link_ack_timers.sv
// Behaviour
// - after I response or I command P=0, idle queue: delay S ack by percent
// - response percent loads from parameter exchange message or local table
// - valid short type 2 frame: two flags, two addresses, control, check
// - type 2 frame short below 9 octets unnumbered, 10 octets I or S
// - type 3 ack timer runs for reply from the addressed station
// - type 3 ack timer starts only when frame finished transmission
// - type 3 timeout period includes physical sublayer delay
// - receiver-not-ready starts busy timer, default 120 seconds
// - type 3 retransmissions limited to 0..5, default 2
// - type 3 retry limit fixed at protocol initialisation
// - quiet mode suppresses retransmission before limit reached
// - valid type 3 frame at least 9 octets, else invalid
// - type 2 ack timer 10..1800 s, one second steps, default 120
//
// Chosen here: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module link_ack_timers #(
   parameter int CYC_PER_SEC = link_timers_pkg::CYC_PER_SEC
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // axi4-lite write address and data
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // axi4-lite read
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // received frame report
   input wire logic RX_DONE,
   input wire logic [1:0] RX_KIND,
   input wire logic RX_TYPE3,
   input wire logic RX_IS_RESPONSE,
   input wire logic RX_POLL,
   input wire logic [15:0] RX_OCTETS,
   input wire logic TX_QUEUE_EMPTY,
   // parameter exchange message update
   input wire logic XCHG_VALID,
   input wire logic [6:0] XCHG_RESP_PCT,
   // type 3 transmit and acknowledge
   input wire logic T3_SENT,
   input wire logic T3_TX_DONE,
   input wire logic T3_ACK_RX,
   // peer busy condition
   input wire logic UNNUMBERED_RECEIVER_NOT_READY,
   input wire logic PEER_BUSY_CLEAR,
   // outputs
   output logic SEND_S_ACK,
   output logic FRAME_INVALID,
   output logic T3_RETRANSMIT,
   output logic T3_GIVE_UP,
   output logic PEER_BUSY,
   output logic BUSY_TIMEOUT,
   output logic IRQ
);
   localparam int W_SEC = 32;
   logic [10:0] ack2_secs_q;
   logic [6:0] tbl_pct_q, xchg_pct_q, resp_pct;
   logic [15:0] t3_period_q, busy_secs_q;
   logic [2:0] retry_cfg_q, retry_lim_q, retry_cnt_q;
   logic quiet_q, pct_src_q;
   logic [4:0] irq_stat_q, irq_mask_q, ev;
   logic aw_hold_q, w_hold_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic do_wr, strb0_q;
   // one-second tick shared by the type 3 and busy timers
   logic [W_SEC-1:0] pre_q;
   logic tick;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) pre_q <= '0;
      else if (pre_q == W_SEC'(CYC_PER_SEC - 1)) pre_q <= '0;
      else pre_q <= pre_q + 1'b1;
   end
   assign tick = (pre_q == W_SEC'(CYC_PER_SEC - 1));

   // ---- bus write path: address and data taken in either order
   assign AWREADY = !aw_hold_q && !BVALID;
   assign WREADY = !w_hold_q && !BVALID;
   assign do_wr = aw_hold_q && w_hold_q && !BVALID;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         aw_hold_q <= 1'b0;
         w_hold_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         strb0_q <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= 2'h0;
      end else begin
         if (AWVALID && AWREADY) begin
            aw_hold_q <= 1'b1;
            awaddr_q <= AWADDR;
         end
         if (WVALID && WREADY) begin
            w_hold_q <= 1'b1;
            wdata_q <= WDATA;
            strb0_q <= WSTRB[0];
         end
         if (do_wr) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= addr_ok(awaddr_q) ? 2'h0 : 2'h2;
         end else if (BVALID && BREADY) BVALID <= 1'b0;
      end
   end

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a[1:0] == 2'h0) && (a <= link_timers_pkg::OFF_INT_MASK);
   endfunction

   function automatic logic [10:0] clamp_ack2(input logic [10:0] v);
      if (v < link_timers_pkg::ACK2_SECS_MIN) clamp_ack2 = link_timers_pkg::ACK2_SECS_MIN;
      else if (v > link_timers_pkg::ACK2_SECS_MAX) clamp_ack2 = link_timers_pkg::ACK2_SECS_MAX;
      else clamp_ack2 = v;
   endfunction

   function automatic logic [6:0] clamp_pct(input logic [6:0] v);
      clamp_pct = (v > link_timers_pkg::RESP_PCT_MAX) ? link_timers_pkg::RESP_PCT_MAX : v;
   endfunction

   // configuration registers
   logic init_pulse;
   assign init_pulse = do_wr && awaddr_q == link_timers_pkg::OFF_CTRL && strb0_q
      && wdata_q[link_timers_pkg::CTRL_INIT_BIT];
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         ack2_secs_q <= link_timers_pkg::ACK2_SECS_RST;
         tbl_pct_q <= link_timers_pkg::RESP_PCT_RST;
         t3_period_q <= link_timers_pkg::T3_PERIOD_RST;
         busy_secs_q <= link_timers_pkg::BUSY_SECS_RST;
         retry_cfg_q <= link_timers_pkg::RETRY_RST;
         quiet_q <= 1'b0;
         pct_src_q <= 1'b0;
         irq_mask_q <= '0;
      end else if (do_wr) begin
         unique case (awaddr_q)
            link_timers_pkg::OFF_CTRL: begin
               quiet_q <= wdata_q[link_timers_pkg::CTRL_QUIET_BIT];
               pct_src_q <= wdata_q[link_timers_pkg::CTRL_PCT_SRC_BIT];
            end
            link_timers_pkg::OFF_ACK2_SECS: ack2_secs_q <= clamp_ack2(wdata_q[10:0]);
            link_timers_pkg::OFF_RESP_PCT: tbl_pct_q <= clamp_pct(wdata_q[6:0]);
            // software sets the period including physical sublayer delay
            link_timers_pkg::OFF_T3_PERIOD: t3_period_q <= wdata_q[15:0];
            link_timers_pkg::OFF_BUSY_SECS: busy_secs_q <= wdata_q[15:0];
            link_timers_pkg::OFF_RETRY: begin
               if (wdata_q[2:0] <= link_timers_pkg::RETRY_MAX) retry_cfg_q <= wdata_q[2:0];
            end
            link_timers_pkg::OFF_INT_MASK: irq_mask_q <= wdata_q[4:0];
            default: ;
         endcase
      end
   end

   // retry limit latched only at protocol initialisation
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) retry_lim_q <= link_timers_pkg::RETRY_RST;
      else if (init_pulse) retry_lim_q <= retry_cfg_q;
   end

   // exchange message value
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) xchg_pct_q <= link_timers_pkg::RESP_PCT_RST;
      else if (XCHG_VALID) xchg_pct_q <= clamp_pct(XCHG_RESP_PCT);
   end
   assign resp_pct = pct_src_q ? xchg_pct_q : tbl_pct_q;

   // ---- frame length check
   logic short_frame;
   always_comb begin
      if (RX_TYPE3) short_frame = RX_OCTETS < link_timers_pkg::MIN_LEN_T3;
      else if (RX_KIND == link_timers_pkg::FRAME_U)
         short_frame = RX_OCTETS < link_timers_pkg::MIN_LEN_U;
      else short_frame = RX_OCTETS < link_timers_pkg::MIN_LEN_IS;
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) FRAME_INVALID <= 1'b0;
      else FRAME_INVALID <= RX_DONE && short_frame;
   end

   // ---- delayed type 2 acknowledgment, counted in hundredths of a second
   logic [17:0] dly_target, dly_cnt_q;
   logic dly_run_q, trig_ack;
   logic [W_SEC-1:0] cpre_q;
   logic ctick;
   assign dly_target = 18'(ack2_secs_q * resp_pct);
   assign trig_ack = RX_DONE && !short_frame && !RX_TYPE3
      && RX_KIND == link_timers_pkg::FRAME_I && (RX_IS_RESPONSE || !RX_POLL)
      && TX_QUEUE_EMPTY;
   assign ctick = (cpre_q == W_SEC'(CYC_PER_SEC / 100 - 1));
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         dly_run_q <= 1'b0;
         dly_cnt_q <= '0;
         cpre_q <= '0;
         SEND_S_ACK <= 1'b0;
      end else begin
         SEND_S_ACK <= 1'b0;
         cpre_q <= (ctick || trig_ack) ? '0 : cpre_q + 1'b1;
         if (trig_ack) begin
            dly_run_q <= 1'b1;
            dly_cnt_q <= '0;
         end else if (dly_run_q && dly_cnt_q >= dly_target) begin
            dly_run_q <= 1'b0;
            SEND_S_ACK <= 1'b1;
         end else if (dly_run_q && ctick) dly_cnt_q <= dly_cnt_q + 1'b1;
      end
   end

   // ---- type 3 acknowledgment timer and retries
   link_timers_pkg::t3_state_t t3_q;
   logic [15:0] t3_secs_q;
   logic t3_expire;
   assign t3_expire = t3_q == link_timers_pkg::T3_RUN && tick && t3_secs_q >= t3_period_q;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         t3_q <= link_timers_pkg::T3_IDLE;
         t3_secs_q <= '0;
         retry_cnt_q <= '0;
         T3_RETRANSMIT <= 1'b0;
         T3_GIVE_UP <= 1'b0;
      end else begin
         T3_RETRANSMIT <= 1'b0;
         T3_GIVE_UP <= 1'b0;
         if (T3_ACK_RX || init_pulse) begin
            t3_q <= link_timers_pkg::T3_IDLE;
            retry_cnt_q <= '0;
         end else begin
            unique case (t3_q)
               link_timers_pkg::T3_IDLE: if (T3_SENT) t3_q <= link_timers_pkg::T3_WAIT_TX;
               link_timers_pkg::T3_WAIT_TX: begin
                  if (T3_TX_DONE) begin
                     t3_q <= link_timers_pkg::T3_RUN;
                     t3_secs_q <= '0;
                  end
               end
               link_timers_pkg::T3_RUN: begin
                  if (t3_expire) begin
                     if (quiet_q || retry_cnt_q >= retry_lim_q) begin
                        T3_GIVE_UP <= 1'b1;
                        t3_q <= link_timers_pkg::T3_IDLE;
                        retry_cnt_q <= '0;
                     end else begin
                        T3_RETRANSMIT <= 1'b1;
                        retry_cnt_q <= retry_cnt_q + 1'b1;
                        t3_q <= link_timers_pkg::T3_WAIT_TX;
                     end
                  end else if (tick) t3_secs_q <= t3_secs_q + 1'b1;
               end
               default: t3_q <= link_timers_pkg::T3_IDLE;
            endcase
         end
      end
   end

   // ---- busy-state timer
   logic [15:0] busy_cnt_q;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         PEER_BUSY <= 1'b0;
         busy_cnt_q <= '0;
         BUSY_TIMEOUT <= 1'b0;
      end else begin
         BUSY_TIMEOUT <= 1'b0;
         if (UNNUMBERED_RECEIVER_NOT_READY) begin
            PEER_BUSY <= 1'b1;
            busy_cnt_q <= '0;
         end else if (PEER_BUSY_CLEAR) begin
            PEER_BUSY <= 1'b0;
            busy_cnt_q <= '0;
         end else if (PEER_BUSY && tick) begin
            if (busy_cnt_q + 16'h0001 >= busy_secs_q) begin
               PEER_BUSY <= 1'b0;
               BUSY_TIMEOUT <= 1'b1;
            end else busy_cnt_q <= busy_cnt_q + 1'b1;
         end
      end
   end

   // ---- interrupts: set wins over write-one-to-clear
   assign ev = {FRAME_INVALID, BUSY_TIMEOUT, T3_GIVE_UP, T3_RETRANSMIT, SEND_S_ACK};
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) irq_stat_q <= '0;
      else if (do_wr && awaddr_q == link_timers_pkg::OFF_INT_STAT)
         irq_stat_q <= (irq_stat_q & ~wdata_q[4:0]) | ev;
      else irq_stat_q <= irq_stat_q | ev;
   end
   // a set mask bit hides its status bit
   assign IRQ = |(irq_stat_q & ~irq_mask_q);

   // ---- bus read path
   assign ARREADY = !RVALID;
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         RVALID <= 1'b0;
         RDATA <= '0;
         RRESP <= 2'h0;
      end else if (ARVALID && ARREADY) begin
         RVALID <= 1'b1;
         RRESP <= addr_ok(ARADDR) ? 2'h0 : 2'h2;
         unique case (ARADDR)
            link_timers_pkg::OFF_CTRL: RDATA <= {29'h0, pct_src_q, 1'b0, quiet_q};
            link_timers_pkg::OFF_ACK2_SECS: RDATA <= {21'h0, ack2_secs_q};
            link_timers_pkg::OFF_RESP_PCT: RDATA <= {25'h0, resp_pct};
            link_timers_pkg::OFF_T3_PERIOD: RDATA <= {16'h0, t3_period_q};
            link_timers_pkg::OFF_BUSY_SECS: RDATA <= {16'h0, busy_secs_q};
            link_timers_pkg::OFF_RETRY: RDATA <= {25'h0, retry_cnt_q, 1'b0, retry_lim_q};
            link_timers_pkg::OFF_STATUS: RDATA <= {28'h0, t3_q, PEER_BUSY, dly_run_q};
            link_timers_pkg::OFF_INT_STAT: RDATA <= {27'h0, irq_stat_q};
            link_timers_pkg::OFF_INT_MASK: RDATA <= {27'h0, irq_mask_q};
            default: RDATA <= 32'h0;
         endcase
      end else if (RVALID && RREADY) RVALID <= 1'b0;
   end

   // ---- checks
   chk_retry_bound: assert property (@(posedge CLOCK) disable iff (!RSTN)
      retry_cnt_q <= retry_lim_q) else $error("retry count above limit");
   chk_ack_clears: assert property (@(posedge CLOCK) disable iff (!RSTN)
      T3_ACK_RX |=> t3_q == link_timers_pkg::T3_IDLE && retry_cnt_q == 3'h0)
      else $error("ack did not stop timer");
   chk_quiet_no_retx: assert property (@(posedge CLOCK) disable iff (!RSTN)
      quiet_q && t3_expire && !T3_ACK_RX && !init_pulse |=> !T3_RETRANSMIT && T3_GIVE_UP)
      else $error("retransmit in quiet mode");
   chk_start_after_tx: assert property (@(posedge CLOCK) disable iff (!RSTN)
      $rose(t3_q == link_timers_pkg::T3_RUN) |-> $past(T3_TX_DONE))
      else $error("timer started before tx done");
   chk_short_u: assert property (@(posedge CLOCK) disable iff (!RSTN)
      RX_DONE && !RX_TYPE3 && RX_KIND == link_timers_pkg::FRAME_U && RX_OCTETS == 16'h0008
      |=> FRAME_INVALID) else $error("short U frame accepted");
   chk_ok_is: assert property (@(posedge CLOCK) disable iff (!RSTN)
      RX_DONE && !RX_TYPE3 && RX_KIND == link_timers_pkg::FRAME_I && RX_OCTETS == 16'h000A
      |=> !FRAME_INVALID) else $error("valid I frame rejected");
   chk_short_t3: assert property (@(posedge CLOCK) disable iff (!RSTN)
      RX_DONE && RX_TYPE3 && RX_OCTETS < 16'h0009 |=> FRAME_INVALID)
      else $error("short type 3 frame accepted");
   chk_busy_start: assert property (@(posedge CLOCK) disable iff (!RSTN)
      UNNUMBERED_RECEIVER_NOT_READY |=> PEER_BUSY && busy_cnt_q == 16'h0)
      else $error("busy timer not started");
   chk_busy_clear: assert property (@(posedge CLOCK) disable iff (!RSTN)
      PEER_BUSY_CLEAR && !UNNUMBERED_RECEIVER_NOT_READY
      |=> !PEER_BUSY ##1 (!PEER_BUSY || $past(UNNUMBERED_RECEIVER_NOT_READY)))
      else $error("busy not cleared");
   chk_limit_fixed: assert property (@(posedge CLOCK) disable iff (!RSTN)
      !init_pulse |=> $stable(retry_lim_q)) else $error("limit changed outside init");
   chk_ack_trig: assert property (@(posedge CLOCK) disable iff (!RSTN)
      trig_ack |=> dly_run_q || SEND_S_ACK) else $error("delayed ack not armed");
   sequence s_retry_left;
      t3_expire && !quiet_q && retry_cnt_q < retry_lim_q && !T3_ACK_RX && !init_pulse;
   endsequence
   sequence s_retx_step;
      T3_RETRANSMIT && t3_q == link_timers_pkg::T3_WAIT_TX;
   endsequence
   chk_retx_step: assert property (@(posedge CLOCK) disable iff (!RSTN)
      s_retry_left |=> s_retx_step) else $error("no retransmit with retries left");
endmodule
`default_nettype wire

// file: design/link_timers_pkg.sv
package link_timers_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ACK2_SECS = 8'h04;
   localparam logic [7:0] OFF_RESP_PCT = 8'h08;
   localparam logic [7:0] OFF_T3_PERIOD = 8'h0C;
   localparam logic [7:0] OFF_BUSY_SECS = 8'h10;
   localparam logic [7:0] OFF_RETRY = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h18;
   localparam logic [7:0] OFF_INT_STAT = 8'h1C;
   localparam logic [7:0] OFF_INT_MASK = 8'h20;
   // control fields
   localparam int CTRL_QUIET_BIT = 0;
   localparam int CTRL_INIT_BIT = 1;
   localparam int CTRL_PCT_SRC_BIT = 2;
   // interrupt status fields
   localparam int IRQ_ACK2_BIT = 0;
   localparam int IRQ_T3_TIMEOUT_BIT = 1;
   localparam int IRQ_GIVE_UP_BIT = 2;
   localparam int IRQ_BUSY_TO_BIT = 3;
   localparam int IRQ_SHORT_BIT = 4;
   localparam int IRQ_W = 5;
   // reset values and limits
   localparam logic [10:0] ACK2_SECS_RST = 11'h078;
   localparam logic [10:0] ACK2_SECS_MIN = 11'h00A;
   localparam logic [10:0] ACK2_SECS_MAX = 11'h708;
   localparam logic [6:0] RESP_PCT_RST = 7'h00;
   localparam logic [6:0] RESP_PCT_MAX = 7'h63;
   localparam logic [15:0] T3_PERIOD_RST = 16'h0078;
   localparam logic [15:0] BUSY_SECS_RST = 16'h0078;
   localparam logic [2:0] RETRY_RST = 3'h2;
   localparam logic [2:0] RETRY_MAX = 3'h5;
   // frame minimum lengths in octets
   localparam logic [15:0] MIN_LEN_U = 16'h0009;
   localparam logic [15:0] MIN_LEN_IS = 16'h000A;
   localparam logic [15:0] MIN_LEN_T3 = 16'h0009;
   // timing
   localparam int CLK_HZ = 100_000_000;
   localparam int SEC_NS = 1_000_000_000;
   localparam int CLK_NS = 10;
   localparam int CYC_PER_SEC = SEC_NS / CLK_NS;
   // frame kinds
   typedef enum logic [1:0] {
      FRAME_U = 2'h0,
      FRAME_I = 2'h1,
      FRAME_S = 2'h2
   } frame_kind_t;
   typedef enum logic [1:0] {
      T3_IDLE = 2'b00,
      T3_WAIT_TX = 2'b01,
      T3_RUN = 2'b11
   } t3_state_t;
endpackage

// file: verif/link_peer_model.sv
`timescale 1ns/1ns
`default_nettype none
module link_peer_model (
   // clock
   input wire logic clk,
   // received frame report
   output logic rx_done,
   output logic [1:0] rx_kind,
   output logic rx_type3,
   output logic rx_is_response,
   output logic rx_poll,
   output logic [15:0] rx_octets,
   // exchange message
   output logic xchg_valid,
   output logic [6:0] xchg_resp_pct,
   // peer events
   output logic t3_ack_rx,
   output logic rnr,
   output logic busy_clear
);
   initial begin
      {rx_done, rx_kind, rx_type3, rx_is_response, rx_poll, rx_octets} = '0;
      {xchg_valid, xchg_resp_pct, t3_ack_rx, rnr, busy_clear} = '0;
   end
   // qualifiers are inverted once the strobe drops so stale values differ from the last frame
   task frame(input logic [1:0] k, input logic t3, r, p, input logic [15:0] n);
      @(posedge clk);
      rx_done <= 1'b1;
      rx_kind <= k;
      rx_type3 <= t3;
      rx_is_response <= r;
      rx_poll <= p;
      rx_octets <= n;
      @(posedge clk);
      rx_done <= 1'b0;
      rx_kind <= ~k;
      rx_type3 <= ~t3;
      rx_is_response <= ~r;
      rx_poll <= ~p;
      rx_octets <= ~n;
   endtask
   // 0 receiver not ready, 1 busy cleared, 2 ack, 3 exchange message
   task ev(input int w, input logic [6:0] v);
      @(posedge clk);
      rnr <= (w == 0);
      busy_clear <= (w == 1);
      t3_ack_rx <= (w == 2);
      xchg_valid <= (w == 3);
      xchg_resp_pct <= v;
      @(posedge clk);
      {rnr, busy_clear, t3_ack_rx, xchg_valid} <= 4'h0;
      xchg_resp_pct <= ~v;
   endtask
endmodule
`default_nettype wire

// file: verif/link_ack_timers_retry_limits_tb.sv
`timescale 1ns/1ns
`default_nettype none
module link_ack_timers_retry_limits_tb;
   localparam logic [7:0] A_CTRL = link_timers_pkg::OFF_CTRL;
   localparam logic [7:0] A_ACK2 = link_timers_pkg::OFF_ACK2_SECS;
   localparam logic [7:0] A_PCT = link_timers_pkg::OFF_RESP_PCT;
   localparam logic [7:0] A_RETRY = link_timers_pkg::OFF_RETRY;
   logic clock = 1'b0, rstn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hF;
   logic t3_sent = 1'b0, t3_tx_done = 1'b0, tx_queue_empty = 1'b1;
   logic awready, wready, bvalid, arready, rvalid, send_s_ack, frame_invalid;
   logic t3_retransmit, t3_give_up, peer_busy, busy_timeout, irq;
   logic [1:0] bresp, rresp, rx_kind;
   logic [31:0] rdata;
   logic rx_done, rx_type3, rx_resp, rx_poll, xchg_valid, t3_ack_rx, rnr, busy_clear;
   logic [15:0] rx_octets;
   logic [6:0] xchg_pct;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   int miscompares = 0, check_count = 0, seed = 32'hC7AF, i, k, n, v;
   always #5 clock = ~clock;
   link_ack_timers #(.CYC_PER_SEC(200)) u_dut (.CLOCK(clock), .RSTN(rstn),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
      .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .RX_DONE(rx_done), .RX_KIND(rx_kind),
      .RX_TYPE3(rx_type3), .RX_IS_RESPONSE(rx_resp), .RX_POLL(rx_poll), .RX_OCTETS(rx_octets),
      .TX_QUEUE_EMPTY(tx_queue_empty), .XCHG_VALID(xchg_valid), .XCHG_RESP_PCT(xchg_pct),
      .T3_SENT(t3_sent), .T3_TX_DONE(t3_tx_done), .T3_ACK_RX(t3_ack_rx),
      .UNNUMBERED_RECEIVER_NOT_READY(rnr), .PEER_BUSY_CLEAR(busy_clear),
      .SEND_S_ACK(send_s_ack), .FRAME_INVALID(frame_invalid), .T3_RETRANSMIT(t3_retransmit),
      .T3_GIVE_UP(t3_give_up), .PEER_BUSY(peer_busy), .BUSY_TIMEOUT(busy_timeout), .IRQ(irq));
   link_peer_model u_peer (.clk(clock), .rx_done(rx_done), .rx_kind(rx_kind),
      .rx_type3(rx_type3), .rx_is_response(rx_resp), .rx_poll(rx_poll), .rx_octets(rx_octets),
      .xchg_valid(xchg_valid), .xchg_resp_pct(xchg_pct), .t3_ack_rx(t3_ack_rx), .rnr(rnr),
      .busy_clear(busy_clear));
   task end_sim;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk_val(input logic [33:0] got, input logic [33:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_win(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi) begin
         miscompares++;
         $display("ERROR t=%0t cycle got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   task tmo;
      miscompares++;
      $display("ERROR t=%0t bus wait got=%h exp=%h", $time, 0, 1);
      end_sim;
   endtask
   // outputs are looked at 1 ns after each edge; -1 means never seen
   function logic sel(input int w);
      case (w)
         0: sel = send_s_ack;
         1: sel = t3_retransmit;
         2: sel = t3_give_up;
         3: sel = busy_timeout;
         default: sel = frame_invalid;
      endcase
   endfunction
   task win(input int w, input int lo, input int hi, input int len);
      int f;
      f = -1;
      for (int j = 0; j <= len; j++) begin
         if (j > 0)
            @(posedge clock);
         #1;
         if (f < 0 && sel(w) === 1'b1)
            f = j;
      end
      chk_win(f, lo, hi);
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int j;
      bq.push_back(r);
      @(posedge clock);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      for (j = 0; j < 200; j++) begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (j == 200) tmo();
   endtask
   task rd(input logic [7:0] a, input logic [33:0] e);
      int j;
      rq.push_back(e);
      @(posedge clock);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (j = 0; j < 200; j++) begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      if (j == 200) tmo();
   endtask
   task tx(input int w);
      @(posedge clock);
      t3_sent <= (w == 0);
      t3_tx_done <= (w == 1);
      @(posedge clock);
      {t3_sent, t3_tx_done} <= 2'h0;
   endtask
   // bus answers are compared against the oldest note left by the driver
   always @(posedge clock) begin
      if (bvalid && bready) chk_val({32'h0, bresp}, {32'h0, bq.pop_front()});
      if (rvalid && rready) chk_val({rresp, rdata}, rq.pop_front());
   end
   initial begin
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      rd(A_ACK2, 34'h078);
      rd(link_timers_pkg::OFF_T3_PERIOD, 34'h078);
      rd(link_timers_pkg::OFF_BUSY_SECS, 34'h078);
      rd(A_RETRY, 34'h002);
      rd(8'h24, {2'h2, 32'h0});
      wr(8'h24, 32'h1, 2'h2);
      for (k = 0; k < 4; k++) begin
         n = (k == 1 || k == 2) ? 10 : 9;
         u_peer.frame(k[1:0] & {2{k != 3}}, k == 3, 1'b0, 1'b1, 16'(n - 1));
         win(4, 0, 0, 2);
         u_peer.frame(k[1:0] & {2{k != 3}}, k == 3, 1'b0, 1'b1, 16'(n));
         win(4, -1, -1, 2);
         u_peer.frame(k[1:0] & {2{k != 3}}, k == 3, 1'b0, 1'b1, 16'(n + ($random(seed) & 255)));
         win(4, -1, -1, 2);
      end
      // a set mask bit hides its status bit
      wr(link_timers_pkg::OFF_INT_MASK, 32'h00, 2'h0);
      #1 chk_val({33'h0, irq}, 34'h1);
      wr(link_timers_pkg::OFF_INT_MASK, 32'h1F, 2'h0);
      #1 chk_val({33'h0, irq}, 34'h0);
      wr(link_timers_pkg::OFF_INT_STAT, 32'h1F, 2'h0);
      rd(link_timers_pkg::OFF_INT_STAT, 34'h0);
      wr(link_timers_pkg::OFF_INT_MASK, 32'h00, 2'h0);
      #1 chk_val({33'h0, irq}, 34'h0);
      wr(A_ACK2, 32'h5, 2'h0);
      rd(A_ACK2, 34'h00A);
      wr(A_PCT, 32'h5, 2'h0);
      rd(A_PCT, 34'h005);
      u_peer.frame(2'h1, 1'b0, 1'b1, 1'b0, 16'hA);
      win(0, 95, 110, 150);
      u_peer.frame(2'h1, 1'b0, 1'b0, 1'b1, 16'hA);
      win(0, -1, -1, 150);
      @(posedge clock) tx_queue_empty <= 1'b0;
      u_peer.frame(2'h1, 1'b0, 1'b1, 1'b0, 16'hA);
      win(0, -1, -1, 150);
      @(posedge clock) tx_queue_empty <= 1'b1;
      wr(A_CTRL, 32'h4, 2'h0);
      v = {$random(seed)} % 100;
      u_peer.ev(3, 7'(v));
      rd(A_PCT, 34'(v));
      u_peer.ev(3, 7'h78);
      rd(A_PCT, 34'h063);
      u_peer.ev(3, 7'h00);
      u_peer.frame(2'h1, 1'b0, 1'b0, 1'b0, 16'hA);
      win(0, 1, 4, 10);
      wr(A_CTRL, 32'h0, 2'h0);
      u_peer.ev(0, 7'h0);
      #1 chk_val({33'h0, peer_busy}, 34'h1);
      u_peer.ev(1, 7'h0);
      #1 chk_val({33'h0, peer_busy}, 34'h0);
      win(3, -1, -1, 500);
      wr(link_timers_pkg::OFF_BUSY_SECS, 32'h2, 2'h0);
      u_peer.ev(0, 7'h0);
      win(3, 200, 400, 700);
      chk_val({33'h0, peer_busy}, 34'h0);
      wr(link_timers_pkg::OFF_T3_PERIOD, 32'h2, 2'h0);
      wr(A_RETRY, 32'h1, 2'h0);
      wr(A_CTRL, 32'h2, 2'h0);
      rd(A_RETRY, 34'h001);
      tx(0);
      rd(link_timers_pkg::OFF_STATUS, 34'h004);
      win(1, -1, -1, 700);
      tx(1);
      win(1, 400, 600, 700);
      rd(A_RETRY, 34'h011);
      wr(A_RETRY, 32'h3, 2'h0);
      rd(A_RETRY, 34'h011);
      tx(1);
      win(2, 400, 600, 700);
      wr(A_CTRL, 32'h2, 2'h0);
      rd(A_RETRY, 34'h003);
      wr(A_RETRY, 32'h6, 2'h0);
      wr(A_CTRL, 32'h2, 2'h0);
      rd(A_RETRY, 34'h003);
      wr(A_CTRL, 32'h1, 2'h0);
      tx(0);
      tx(1);
      win(2, 400, 600, 700);
      wr(A_CTRL, 32'h0, 2'h0);
      tx(0);
      tx(1);
      repeat (50) @(posedge clock);
      u_peer.ev(2, 7'h0);
      win(1, -1, -1, 700);
      rd(A_RETRY, 34'h003);
      end_sim;
   end
endmodule
`default_nettype wire
